// [rtl/iocs_consts.svh]
// Register offsets, field positions and reset values of the io_cell control block
`ifndef IOCS_CONSTS_SVH
`define IOCS_CONSTS_SVH

`define IOCS_ADDR_CFG 8'h00
`define IOCS_ADDR_CTRL 8'h04
`define IOCS_ADDR_STATUS 8'h08
`define IOCS_ADDR_SCAN 8'h0c

`define IOCS_CFG_IN_LATCH 0
`define IOCS_CFG_OUT_LATCH 1
`define IOCS_CFG_OE_LATCH 2
`define IOCS_CFG_IN_SRM 3
`define IOCS_CFG_OUT_SRM 5
`define IOCS_CFG_OE_SRM 7
`define IOCS_CFG_INV_CLK 9
`define IOCS_CFG_INV_CE_IN 10
`define IOCS_CFG_INV_CE_OUT 11
`define IOCS_CFG_INV_CE_OE 12
`define IOCS_CFG_INV_SR 13
`define IOCS_CFG_INV_OUT 14
`define IOCS_CFG_INV_OE 15
`define IOCS_CFG_IN_SEL 16
`define IOCS_CFG_OUT_SEL 17
`define IOCS_CFG_OE_SEL 18
`define IOCS_CFG_PULLUP 19
`define IOCS_CFG_PULLDOWN 20
`define IOCS_CFG_KEEPER 21
`define IOCS_CFG_MASK 32'h003fffff
`define IOCS_CFG_RST 32'h00000000

`define IOCS_CTRL_DONE 0

`define IOCS_SRM_SYNC_SET 2'h0
`define IOCS_SRM_SYNC_RESET 2'h1
`define IOCS_SRM_ASYNC_PRESET 2'h2
`define IOCS_SRM_ASYNC_CLEAR 2'h3

`endif

// [rtl/iocs_pkg.sv]
// Types of the io_cell control block
`default_nettype none
package iocs_pkg;
   typedef struct packed {
      logic [31:0] cfg;
      logic done;
      logic [1:0] pad_sync;
      logic [1:0] mode_sync;
      logic clk_prev;
      logic in_q;
      logic out_q;
      logic oe_q;
      logic [2:0] scan_sh;
      logic [2:0] scan_up;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic pad_out;
      logic pad_oe;
      logic pad_pullup_en;
      logic pad_pulldown_en;
      logic pad_keeper_en;
      logic fabric_in_data;
      logic scan_tdo;
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } iocs_state_t;
endpackage
`default_nettype wire

// [rtl/iocs_io_cell.sv]
// One io_cell with three storage elements, pad control and an AHB-Lite register slave
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`include "iocs_consts.svh"
`default_nettype none

// What this block does
// - Input, output and enable elements each act as flip-flop or transparent latch.
// - One shared cell clock; each element has its own clock enable.
// - Shared set/reset line; per element sync set, sync reset, async preset or clear.
// - Output path and every control input have their own polarity inversion.
// - Before configuration completes the pad is never driven.
// - Before configuration pull-down and keeper stay off.
// - Pre-configuration pull-up follows the global mode input; otherwise pad floats.
// - The cell sits in a boundary-scan chain with capture, shift and update.
// - Pad input reaches fabric directly or through the input element.
// - Output data and enable pass directly or through their own element.
module iocs_io_cell
   import iocs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic pad_pullup_en,
   output logic pad_pulldown_en,
   output logic pad_keeper_en,
   input wire logic cfg_mode_pullup,
   input wire logic cell_clk,
   input wire logic ce_in,
   input wire logic ce_out,
   input wire logic ce_oe,
   input wire logic shared_set_reset_line,
   input wire logic fabric_out_data,
   input wire logic fabric_oe,
   output logic fabric_in_data,
   input wire logic scan_mode,
   input wire logic scan_capture,
   input wire logic scan_shift,
   input wire logic scan_update,
   input wire logic scan_tdi,
   output logic scan_tdo
);

   iocs_state_t s;
   iocs_state_t next_s;

   logic clk_lvl;
   logic clk_rise;
   logic sr_eff;
   logic ce_in_eff;
   logic ce_out_eff;
   logic ce_oe_eff;
   logic out_d;
   logic oe_d;
   logic addr_ok;

   // One storage element: async modes act at once, sync ones only when the element is open
   function automatic logic elem_next(input logic q, input logic d, input logic latch,
                                      input logic [1:0] srm, input logic lvl, input logic rise,
                                      input logic ce, input logic sr);
      logic open_now;
      open_now = latch ? lvl : rise;
      if (sr && (srm == `IOCS_SRM_ASYNC_PRESET))
         elem_next = 1'b1;
      else if (sr && (srm == `IOCS_SRM_ASYNC_CLEAR))
         elem_next = 1'b0;
      else if (open_now && sr)
         elem_next = (srm == `IOCS_SRM_SYNC_SET);
      else if (open_now && ce)
         elem_next = d;
      else
         elem_next = q;
   endfunction

   function automatic logic [31:0] reg_read(input iocs_state_t r, input logic [7:0] a);
      reg_read = 32'h00000000;
      unique case (a)
         `IOCS_ADDR_CFG: reg_read = r.cfg;
         `IOCS_ADDR_CTRL: reg_read = {31'h00000000, r.done};
         `IOCS_ADDR_STATUS: reg_read = {26'h0000000, r.mode_sync[1], r.pad_sync[1], r.done,
                                        r.oe_q, r.out_q, r.in_q};
         `IOCS_ADDR_SCAN: reg_read = {26'h0000000, r.scan_up, r.scan_sh};
         default: reg_read = 32'h00000000;
      endcase
   endfunction

   // Control inputs after their polarity bits
   assign clk_lvl = cell_clk ^ s.cfg[`IOCS_CFG_INV_CLK];
   assign clk_rise = clk_lvl && !s.clk_prev;
   assign sr_eff = shared_set_reset_line ^ s.cfg[`IOCS_CFG_INV_SR];
   assign ce_in_eff = ce_in ^ s.cfg[`IOCS_CFG_INV_CE_IN];
   assign ce_out_eff = ce_out ^ s.cfg[`IOCS_CFG_INV_CE_OUT];
   assign ce_oe_eff = ce_oe ^ s.cfg[`IOCS_CFG_INV_CE_OE];
   assign out_d = fabric_out_data ^ s.cfg[`IOCS_CFG_INV_OUT];
   assign oe_d = fabric_oe ^ s.cfg[`IOCS_CFG_INV_OE];
   assign addr_ok = (haddr[31:8] == 24'h000000);

   always_comb
   begin
      logic drive;
      logic oe_val;
      drive = 1'b0;
      oe_val = 1'b0;
      next_s = s;
      next_s.pad_sync = {s.pad_sync[0], pad_in};
      next_s.mode_sync = {s.mode_sync[0], cfg_mode_pullup};
      next_s.clk_prev = clk_lvl;
      next_s.hreadyout = 1'b1;
      next_s.hresp = 1'b0;

      // Bus data phase of a pending write
      next_s.wr_pend = 1'b0;
      if (s.wr_pend)
      begin
         if ((s.wr_addr == `IOCS_ADDR_CFG) && !s.done)
            next_s.cfg = hwdata & `IOCS_CFG_MASK;
         if (s.wr_addr == `IOCS_ADDR_CTRL)
            next_s.done = hwdata[`IOCS_CTRL_DONE];
      end
      // Bus address phase; reads see any write finishing this cycle
      if (hsel && htrans[1] && hready)
      begin
         next_s.wr_pend = hwrite && addr_ok;
         next_s.wr_addr = haddr[7:0];
         if (!hwrite)
            next_s.hrdata = addr_ok ? reg_read(next_s, haddr[7:0]) : 32'h00000000;
      end

      // Storage elements run only once configured
      if (s.done)
      begin
         next_s.in_q = elem_next(s.in_q, s.pad_sync[1], s.cfg[`IOCS_CFG_IN_LATCH],
                                 s.cfg[`IOCS_CFG_IN_SRM +: 2], clk_lvl, clk_rise, ce_in_eff, sr_eff);
         next_s.out_q = elem_next(s.out_q, out_d, s.cfg[`IOCS_CFG_OUT_LATCH],
                                  s.cfg[`IOCS_CFG_OUT_SRM +: 2], clk_lvl, clk_rise, ce_out_eff, sr_eff);
         next_s.oe_q = elem_next(s.oe_q, oe_d, s.cfg[`IOCS_CFG_OE_LATCH],
                                 s.cfg[`IOCS_CFG_OE_SRM +: 2], clk_lvl, clk_rise, ce_oe_eff, sr_eff);
      end

      // Boundary-scan chain: input, output, enable
      if (scan_capture)
         next_s.scan_sh = {s.pad_sync[1], s.pad_out, s.pad_oe};
      else if (scan_shift)
         next_s.scan_sh = {scan_tdi, s.scan_sh[2:1]};
      if (scan_update)
         next_s.scan_up = s.scan_sh;
      next_s.scan_tdo = next_s.scan_sh[0];

      // Paths to fabric and pad
      next_s.fabric_in_data = s.cfg[`IOCS_CFG_IN_SEL] ? next_s.in_q : s.pad_sync[1];
      next_s.pad_out = s.cfg[`IOCS_CFG_OUT_SEL] ? next_s.out_q : out_d;
      oe_val = s.cfg[`IOCS_CFG_OE_SEL] ? next_s.oe_q : oe_d;
      if (scan_mode)
      begin
         next_s.pad_out = s.scan_up[1];
         oe_val = s.scan_up[0];
      end
      drive = s.done && oe_val;
      next_s.pad_oe = drive;
      next_s.pad_pulldown_en = s.done && s.cfg[`IOCS_CFG_PULLDOWN];
      next_s.pad_keeper_en = s.done && s.cfg[`IOCS_CFG_KEEPER];
      next_s.pad_pullup_en = s.done ? s.cfg[`IOCS_CFG_PULLUP] : s.mode_sync[1];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
         s.cfg <= `IOCS_CFG_RST;
         s.hreadyout <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign hrdata = s.hrdata;
   assign pad_out = s.pad_out;
   assign pad_oe = s.pad_oe;
   assign pad_pullup_en = s.pad_pullup_en;
   assign pad_pulldown_en = s.pad_pulldown_en;
   assign pad_keeper_en = s.pad_keeper_en;
   assign fabric_in_data = s.fabric_in_data;
   assign scan_tdo = s.scan_tdo;

   // Checks
   property p_preconfig_hiz;
      @(posedge hclk) disable iff (!hresetn) !s.done |=> !pad_oe;
   endproperty
   a_preconfig_hiz: assert property (p_preconfig_hiz) else $error("pad driven before config");

   property p_preconfig_pull;
      @(posedge hclk) disable iff (!hresetn) !s.done |=> (!pad_pulldown_en && !pad_keeper_en);
   endproperty
   a_preconfig_pull: assert property (p_preconfig_pull) else $error("pull-down or keeper on early");

   property p_preconfig_pullup;
      @(posedge hclk) disable iff (!hresetn) !s.done |=> (pad_pullup_en == $past(s.mode_sync[1]));
   endproperty
   a_preconfig_pullup: assert property (p_preconfig_pullup) else $error("pull-up not from mode");

   property p_async_clear;
      @(posedge hclk) disable iff (!hresetn)
         (s.done && sr_eff && (s.cfg[`IOCS_CFG_OUT_SRM +: 2] == `IOCS_SRM_ASYNC_CLEAR)) |=> !s.out_q;
   endproperty
   a_async_clear: assert property (p_async_clear) else $error("async clear ignored");

   property p_sync_set;
      @(posedge hclk) disable iff (!hresetn)
         (s.done && !s.cfg[`IOCS_CFG_IN_LATCH] && clk_rise && sr_eff
          && (s.cfg[`IOCS_CFG_IN_SRM +: 2] == `IOCS_SRM_SYNC_SET)) |=> s.in_q;
   endproperty
   a_sync_set: assert property (p_sync_set) else $error("sync set ignored");

   property p_ce_hold;
      @(posedge hclk) disable iff (!hresetn) (s.done && !ce_out_eff && !sr_eff) |=> $stable(s.out_q);
   endproperty
   a_ce_hold: assert property (p_ce_hold) else $error("output element moved without enable");

   property p_latch_open;
      @(posedge hclk) disable iff (!hresetn)
         (s.done && s.cfg[`IOCS_CFG_OUT_LATCH] && clk_lvl && !sr_eff && ce_out_eff)
         |=> (s.out_q == $past(out_d));
   endproperty
   a_latch_open: assert property (p_latch_open) else $error("latch not transparent");

   property p_cfg_static;
      @(posedge hclk) disable iff (!hresetn) (s.done && $past(s.done)) |-> $stable(s.cfg);
   endproperty
   a_cfg_static: assert property (p_cfg_static) else $error("config changed while running");

   property p_out_direct;
      @(posedge hclk) disable iff (!hresetn)
         (!scan_mode && !s.cfg[`IOCS_CFG_OUT_SEL]) |=> (pad_out == $past(out_d));
   endproperty
   a_out_direct: assert property (p_out_direct) else $error("direct output path wrong");

   property p_in_direct;
      @(posedge hclk) disable iff (!hresetn)
         !s.cfg[`IOCS_CFG_IN_SEL] |=> (fabric_in_data == $past(s.pad_sync[1]));
   endproperty
   a_in_direct: assert property (p_in_direct) else $error("direct input path wrong");

   property p_scan_update;
      @(posedge hclk) disable iff (!hresetn) scan_update |=> (s.scan_up == $past(s.scan_sh));
   endproperty
   a_scan_update: assert property (p_scan_update) else $error("scan update lost");

   property p_oe_direct;
      @(posedge hclk) disable iff (!hresetn)
         (s.done && !scan_mode && !s.cfg[`IOCS_CFG_OE_SEL]) |=> (pad_oe == $past(oe_d));
   endproperty
   a_oe_direct: assert property (p_oe_direct) else $error("direct enable path wrong");

   property p_async_preset;
      @(posedge hclk) disable iff (!hresetn)
         (s.done && sr_eff && (s.cfg[`IOCS_CFG_OUT_SRM +: 2] == `IOCS_SRM_ASYNC_PRESET)) |=> s.out_q;
   endproperty
   a_async_preset: assert property (p_async_preset) else $error("async preset ignored");

   property p_in_hold;
      @(posedge hclk) disable iff (!hresetn) (s.done && !ce_in_eff && !sr_eff) |=> $stable(s.in_q);
   endproperty
   a_in_hold: assert property (p_in_hold) else $error("input element moved without enable");

   property p_pullup_after;
      @(posedge hclk) disable iff (!hresetn) s.done |=> (pad_pullup_en == $past(s.cfg[`IOCS_CFG_PULLUP]));
   endproperty
   a_pullup_after: assert property (p_pullup_after) else $error("pull-up not from config");

   property p_cov_config;
      @(posedge hclk) disable iff (!hresetn) !s.done ##1 s.done;
   endproperty
   c_cov_config: cover property (p_cov_config);

   property p_cov_drive;
      @(posedge hclk) disable iff (!hresetn) s.done && pad_oe;
   endproperty
   c_cov_drive: cover property (p_cov_drive);

   property p_cov_latch;
      @(posedge hclk) disable iff (!hresetn) s.done && s.cfg[`IOCS_CFG_OUT_LATCH] && clk_lvl && ce_out_eff;
   endproperty
   c_cov_latch: cover property (p_cov_latch);

   property p_cov_scan;
      @(posedge hclk) disable iff (!hresetn) s.done && scan_mode && pad_oe;
   endproperty
   c_cov_scan: cover property (p_cov_scan);

   property p_cov_clear;
      @(posedge hclk) disable iff (!hresetn)
         s.done && sr_eff && (s.cfg[`IOCS_CFG_OUT_SRM +: 2] == `IOCS_SRM_ASYNC_CLEAR);
   endproperty
   c_cov_clear: cover property (p_cov_clear);

endmodule
`default_nettype wire

// [tb/iocs_board.sv]
// Board-side model of the pad: cell driver, external source, pulls and keeper
`default_nettype none
module iocs_board
(
   input wire logic hclk,
   input wire logic pad_out,
   input wire logic pad_oe,
   input wire logic pu,
   input wire logic pd,
   input wire logic kp,
   input wire logic ext_drive,
   input wire logic ext_val,
   output logic pad_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic last = 1'b0;
   logic wobble = 1'b0;
   always @(posedge hclk)
   begin
      last <= pad_in;
      wobble <= ~wobble;
   end
   // Floating pad shows a changing level
   always_comb
      if (pad_oe) pad_in = pad_out;
      else if (ext_drive) pad_in = ext_val;
      else if (pu) pad_in = 1'b1;
      else if (pd) pad_in = 1'b0;
      else if (kp) pad_in = last;
      else pad_in = wobble;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking testbench of the io_cell control block
`include "iocs_consts.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cfg_mode_pullup = 0, cell_clk = 0, sr = 0;
   logic ce_in = 0, ce_out = 0, ce_oe = 0, fod = 0, foe = 1, ext_drive = 0, ext_val = 0;
   logic s_mode = 0, s_cap = 0, s_shift = 0, s_upd = 0, s_tdi = 0, d, e, q, t;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   wire logic hreadyout, hresp, pad_out, pad_oe, pu, pd, kp, fid, tdo, pad_in;
   logic [31:0] hrdata;
   int n_mismatch = 0, checks_done = 0, seed = 20390;
   always #2 hclk = ~hclk;
   iocs_io_cell iocs_io_cell_i(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup_en(pu), .pad_pulldown_en(pd), .pad_keeper_en(kp), .cfg_mode_pullup(cfg_mode_pullup),
      .cell_clk(cell_clk), .ce_in(ce_in), .ce_out(ce_out), .ce_oe(ce_oe), .shared_set_reset_line(sr),
      .fabric_out_data(fod), .fabric_oe(foe), .fabric_in_data(fid), .scan_mode(s_mode),
      .scan_capture(s_cap), .scan_shift(s_shift), .scan_update(s_upd), .scan_tdi(s_tdi), .scan_tdo(tdo));
   iocs_board iocs_board_i(.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe), .pu(pu), .pd(pd), .kp(kp),
      .ext_drive(ext_drive), .ext_val(ext_val), .pad_in(pad_in));
   task automatic results;
      if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge hclk);
   endtask
   task automatic rdy;
      int n;
      for (n = 0; n < 64; n++)
      begin
         @(posedge hclk);
         if (hreadyout === 1'b1) break;
      end
      if (n == 64)
      begin
         n_mismatch++;
         results;
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy;
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic cfg(input logic [31:0] c);
      bus(1'b1, `IOCS_ADDR_CTRL, 32'h0);
      bus(1'b1, `IOCS_ADDR_CFG, c);
      bus(1'b1, `IOCS_ADDR_CTRL, 32'h1);
   endtask
   task automatic pulse;
      cell_clk <= 1'b1;
      tick(1);
      cell_clk <= 1'b0;
      tick(3);
   endtask
   initial
   begin
      tick(8);
      hresetn <= 1'b1;
      tick(1);
      for (int i = 0; i < 2; i++)
      begin
         cfg_mode_pullup <= i[0];
         tick(5);
         chk("pullup", pu, i);
      end
      bus(1'b1, `IOCS_ADDR_CFG, 32'h00320000);
      chk("pulldown", pd, 0);
      chk("keeper", kp, 0);
      chk("oe", pad_oe, 0);
      bus(1'b1, `IOCS_ADDR_CTRL, 32'h1);
      tick(3);
      chk("oe", pad_oe, 1);
      chk("pulldown", pd, 1);
      chk("keeper", kp, 1);
      chk("pullup", pu, 0);
      bus(1'b1, `IOCS_ADDR_CFG, 32'hffffffff);
      bus(1'b0, `IOCS_ADDR_CFG, 32'h0);
      chk("cfg", rd, 32'h00320000);
      bus(1'b0, 32'h10, 32'h0);
      chk("unmapped", rd, 32'h0);
      q = 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         d = $random(seed);
         e = $random(seed);
         fod <= d;
         ce_out <= e;
         pulse;
         if (e) q = d;
         chk("out", pad_out, q);
      end
      for (int m = 0; m < 4; m++)
      begin
         t = (m == 1 || m == 3);
         cfg(32'h00024000 | (m << 5));
         fod <= ~t;
         ce_out <= 1'b1;
         pulse;
         sr <= 1'b1;
         tick(4);
         if (m < 2) chk("sync", pad_out, t);
         if (m < 2) pulse;
         chk("setreset", pad_out, {31'h0, ~t});
         sr <= 1'b0;
      end
      cfg(32'h00020202);
      for (int i = 0; i < 4; i++)
      begin
         d = $random(seed);
         fod <= d;
         tick(2);
         chk("latch open", pad_out, d);
      end
      cell_clk <= 1'b1;
      fod <= ~d;
      tick(3);
      chk("latch shut", pad_out, d);
      cell_clk <= 1'b0;
      foe <= 1'b0;
      ext_drive <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         ext_val <= i[0];
         tick(5);
         chk("direct in", fid, i);
      end
      cfg(32'h00010000);
      ce_in <= 1'b1;
      ext_val <= 1'b0;
      tick(4);
      pulse;
      chk("in", fid, 0);
      ext_val <= 1'b1;
      ce_in <= 1'b0;
      tick(4);
      pulse;
      chk("in hold", fid, 0);
      s_shift <= 1'b1;
      s_tdi <= 1'b1;
      tick(3);
      s_shift <= 1'b0;
      tick(2);
      chk("tdo", tdo, 1);
      bus(1'b0, `IOCS_ADDR_SCAN, 32'h0);
      chk("scan", rd[2:0], 3'h7);
      s_upd <= 1'b1;
      tick(1);
      s_upd <= 1'b0;
      s_mode <= 1'b1;
      s_shift <= 1'b1;
      s_tdi <= 1'b0;
      tick(3);
      s_shift <= 1'b0;
      tick(3);
      chk("scan drive", {pad_oe, pad_out}, 2'h3);
      s_cap <= 1'b1;
      tick(1);
      s_cap <= 1'b0;
      tick(2);
      chk("capture", tdo, 1);
      bus(1'b0, `IOCS_ADDR_SCAN, 32'h0);
      chk("scan reg", rd[5:0], 6'h3f);
      hresetn <= 1'b0;
      tick(2);
      chk("reset oe", pad_oe, 0);
      hresetn <= 1'b1;
      tick(1);
      bus(1'b0, `IOCS_ADDR_CFG, 32'h0);
      chk("reset cfg", rd, `IOCS_CFG_RST);
      results;
   end
   initial
   begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      results;
   end
endmodule
`default_nettype wire
